// file: ldsc_consts.vh
// Constants for the regulator state control register bank.
// Included by the bank module; holds definitions only.
`ifndef LDSC_CONSTS_VH
`define LDSC_CONSTS_VH
`define LDSC_ADDR_INTERNAL 8'h41
`define LDSC_ADDR_CORE18 8'h43
`define LDSC_ADDR_PANEL18 8'h46
`define LDSC_ADDR_RADIO18 8'h4C
`define LDSC_RST_INTERNAL 8'h07
`define LDSC_RST_CORE18 8'h3C
`define LDSC_RST_PANEL18 8'h24
`define LDSC_RST_RADIO18 8'h24
`define LDSC_RUN_MSB 2
`define LDSC_RUN_LSB 0
`define LDSC_EXIT_MSB 5
`define LDSC_EXIT_LSB 3
`define LDSC_ST_OFF 3'h4
`define LDSC_ST_LOWPWR 3'h5
`define LDSC_ST_ACTIVE 3'h6
`define LDSC_ST_ACTIVE_ALT 3'h7
`define LDSC_IDX_INTERNAL 2'h0
`define LDSC_IDX_CORE18 2'h1
`define LDSC_IDX_PANEL18 2'h2
`define LDSC_IDX_RADIO18 2'h3
`endif

// file: ldsc_rail_ctrl.v
// Control registers for four regulator rails, standby-exit copy and
// the shared-rail supply steering. Assumes a host transport (outside)
// presents single-cycle byte reads and writes on core_clk.
//
// Operation
// - Run field: 4 off, 5 low, 6/7 active
// - Standby exit loads exit field into run field
// - Exit field 0..3 no copy, 4..7 copied
// - Registers read/write, documented reset defaults
// - Writing one rail never changes another
// - Discharge rail output when off or shutdown
// - Gps 1.3 V setting raises buck to 1.6 V
// - Radio rail: 1.2 V from buck, or 2.5 V
// - Gps rail: 1.8 V, or 1.3 V from buck
`include "ldsc_consts.vh"
module ldsc_rail_ctrl #(
  parameter NUM_RAILS = 4
) (
  input wire core_clk,
  input wire rstn,
  input wire ce,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  input wire standby_exit_pin,
  input wire shutdown,
  input wire radio_sel_2v5,
  input wire gps_sel_1v3,
  output reg [NUM_RAILS-1:0] rail_enable,
  output reg [NUM_RAILS-1:0] rail_low_power,
  output reg [NUM_RAILS-1:0] rail_discharge,
  output reg dual_radio_from_buck,
  output reg dual_gps_from_buck,
  output reg buck_1v5_raise_1v6
);

  reg [5:0] ctl [0:NUM_RAILS-1];
  reg sync1;
  reg sync2;
  reg sync3;
  reg exit_level;
  reg [NUM_RAILS-1:0] next_enable;
  reg [NUM_RAILS-1:0] next_low_power;
  reg [NUM_RAILS-1:0] next_discharge;
  reg [2:0] dec;
  integer i;
  integer j;

  wire exit_agree = (sync2 == sync3);
  wire exit_rise = exit_agree & sync3 & ~exit_level;

  // Register address to rail index; bit 2 flags a hit
  function [2:0] addr_dec;
    input [7:0] a;
    begin
      case (a)
        `LDSC_ADDR_INTERNAL: addr_dec = {1'b1, `LDSC_IDX_INTERNAL};
        `LDSC_ADDR_CORE18: addr_dec = {1'b1, `LDSC_IDX_CORE18};
        `LDSC_ADDR_PANEL18: addr_dec = {1'b1, `LDSC_IDX_PANEL18};
        `LDSC_ADDR_RADIO18: addr_dec = {1'b1, `LDSC_IDX_RADIO18};
        default: addr_dec = 3'h0;
      endcase
    end
  endfunction

  // Reset value of a rail, stored bits only
  function [5:0] rst_val;
    input [1:0] idx;
    reg [7:0] v;
    begin
      case (idx)
        `LDSC_IDX_INTERNAL: v = `LDSC_RST_INTERNAL;
        `LDSC_IDX_CORE18: v = `LDSC_RST_CORE18;
        `LDSC_IDX_PANEL18: v = `LDSC_RST_PANEL18;
        default: v = `LDSC_RST_RADIO18;
      endcase
      rst_val = v[5:0];
    end
  endfunction

  // Run field to {enable, low power, discharge}; reserved acts as off
  function [2:0] run_decode;
    input [2:0] run;
    input down;
    begin
      case (run)
        `LDSC_ST_LOWPWR: run_decode = down ? 3'h1 : 3'h6;
        `LDSC_ST_ACTIVE: run_decode = down ? 3'h1 : 3'h4;
        `LDSC_ST_ACTIVE_ALT: run_decode = down ? 3'h1 : 3'h4;
        default: run_decode = 3'h1;
      endcase
    end
  endfunction

  wire [2:0] wr_hit = addr_dec(reg_addr);
  wire [2:0] rd_hit = addr_dec(reg_addr);

  // Standby-exit pin: three stages, level taken when last two agree
  always @(posedge core_clk) begin
    if (!rstn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      exit_level <= 1'b0;
    end else if (ce) begin
      sync1 <= standby_exit_pin;
      sync2 <= sync1;
      sync3 <= sync2;
      if (exit_agree)
        exit_level <= sync3;
    end
  end

  // Host write of the same rail wins over a coincident exit copy
  always @(posedge core_clk) begin
    if (!rstn) begin
      for (i = 0; i < NUM_RAILS; i = i + 1)
        ctl[i] <= rst_val(i[1:0]);
    end else if (ce) begin
      for (i = 0; i < NUM_RAILS; i = i + 1) begin
        if (reg_wr && wr_hit[2] && wr_hit[1:0] == i[1:0]) begin
          ctl[i] <= reg_wdata[5:0];
        end else if (exit_rise && ctl[i][`LDSC_EXIT_MSB]) begin
          ctl[i][`LDSC_RUN_MSB:`LDSC_RUN_LSB] <=
            ctl[i][`LDSC_EXIT_MSB:`LDSC_EXIT_LSB];
        end
      end
    end
  end

  // Read port: one cycle latency, unmapped reads zero
  always @(posedge core_clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= rd_hit[2] ? {2'b00, ctl[rd_hit[1:0]]} : 8'h00;
    end
  end

  // Per-rail state decode from the run fields
  always @* begin
    next_enable = {NUM_RAILS{1'b0}};
    next_low_power = {NUM_RAILS{1'b0}};
    next_discharge = {NUM_RAILS{1'b1}};
    dec = 3'h1;
    for (j = 0; j < NUM_RAILS; j = j + 1) begin
      dec = run_decode(ctl[j][`LDSC_RUN_MSB:`LDSC_RUN_LSB], shutdown);
      next_enable[j] = dec[2];
      next_low_power[j] = dec[1];
      next_discharge[j] = dec[0];
    end
  end

  // Rail outputs registered
  always @(posedge core_clk) begin
    if (!rstn) begin
      rail_enable <= {NUM_RAILS{1'b0}};
      rail_low_power <= {NUM_RAILS{1'b0}};
      rail_discharge <= {NUM_RAILS{1'b1}};
      dual_radio_from_buck <= 1'b0;
      dual_gps_from_buck <= 1'b0;
      buck_1v5_raise_1v6 <= 1'b0;
    end else if (ce) begin
      rail_enable <= next_enable;
      rail_low_power <= next_low_power;
      rail_discharge <= next_discharge;
      dual_radio_from_buck <= ~radio_sel_2v5;
      dual_gps_from_buck <= gps_sel_1v3;
      buck_1v5_raise_1v6 <= gps_sel_1v3;
    end
  end

endmodule

// file: ldsc_props.sv
// Checker: rail bank port relations.
// Bound to ldsc_rail_ctrl; ce held high.
module ldsc_props #(parameter NUM_RAILS = 4) (
  input wire logic core_clk, rstn, reg_rd, reg_rvalid, shutdown,
  input wire logic gps_sel_1v3, radio_sel_2v5, buck_1v5_raise_1v6,
  input wire logic dual_gps_from_buck, dual_radio_from_buck,
  input wire logic [7:0] reg_rdata,
  input wire logic [NUM_RAILS-1:0] rail_enable, rail_low_power,
  rail_discharge);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  AST_RV: assert property (reg_rvalid == $past(reg_rd))
    else $error("rv");
  AST_RS: assert property (reg_rvalid |-> !reg_rdata[7:6])
    else $error("rsvd");
  AST_BK: assert property (buck_1v5_raise_1v6 == $past(gps_sel_1v3))
    else $error("buck");
  AST_GP: assert property (dual_gps_from_buck == $past(gps_sel_1v3))
    else $error("gps");
  AST_RA: assert property (
    dual_radio_from_buck != $past(radio_sel_2v5)) else $error("radio");
  AST_SD: assert property (
    shutdown |=> !rail_enable && &rail_discharge) else $error("sd");
  AST_DC: assert property (rail_discharge == ~rail_enable)
    else $error("dis");
  AST_LP: assert property (!(rail_low_power & ~rail_enable))
    else $error("lp");
endmodule
bind ldsc_rail_ctrl ldsc_props #(.NUM_RAILS(NUM_RAILS)) u_props (.*);

// file: ldsc_host.sv
// Host model: single-byte register accesses.
// Drives 1 ns after core_clk rises.
module ldsc_host (
  input wire logic core_clk, reg_rvalid,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr = 0, reg_rd = 0,
  output logic [7:0] reg_addr = 0, reg_wdata = 0);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic acc(logic w, logic [7:0] a, d, output logic [8:0] q);
    @(posedge core_clk) #1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(posedge core_clk) #1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h0, ~a, ~d};
    q = {reg_rvalid, reg_rdata};
  endtask
endmodule

// file: ldsc_rail_ctrl_tb.sv
// Bench: ldsc_rail_ctrl driven through ldsc_host.
// Assumes ce held high.
module ldsc_rail_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rstn = 0, ce = 1, standby_exit_pin = 0, shutdown = 0;
  logic radio_sel_2v5 = 1, gps_sel_1v3 = 0, reg_wr, reg_rd, reg_rvalid;
  logic dual_radio_from_buck, dual_gps_from_buck, buck_1v5_raise_1v6;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] rail_enable, rail_low_power, rail_discharge;
  logic [8:0] q;
  logic [31:0] ad = 32'h4C464341, wv = 32'h252E351F;
  int error_cnt = 0, compares = 0;
  ldsc_rail_ctrl DUT (.*);
  ldsc_host host (.*);
  initial forever #4 core_clk = ~core_clk;
  task automatic chk(logic [8:0] got, exp);
    compares++;
    if (got !== exp) error_cnt++;
    if (got !== exp) $display("FAIL %0t %h %h", $time, got, exp);
  endtask
  task automatic rall(logic [31:0] e);
    for (int i = 0; i < 4; i++) begin
      host.acc(0, ad[i*8+:8], 0, q);
      chk(q, {1'b1, e[i*8+:8]});
    end
  endtask
  task automatic close_out;
    $display("%0d compares, %0d errors", compares, error_cnt);
    if (!error_cnt && compares) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    #1 rstn = 1;
    rall(32'h24243C07);
    host.acc(0, 8'h42, 0, q);
    chk(q, 9'h100);
    for (int i = 0; i < 4; i++)
      host.acc(1, ad[i*8+:8], wv[i*8+:8] | 8'hC0, q);
    rall(wv);
    $display("test 1 done");
    {standby_exit_pin, radio_sel_2v5} = 2'h2;
    repeat (8) @(posedge core_clk);
    #1 standby_exit_pin = 0;
    rall(32'h242D361F);
    chk({rail_low_power, rail_enable}, 9'h047);
    chk({rail_discharge, dual_radio_from_buck}, 9'h011);
    {shutdown, gps_sel_1v3, radio_sel_2v5} = 3'h7;
    repeat (2) @(posedge core_clk);
    #1 chk({rail_enable, buck_1v5_raise_1v6}, 9'h001);
    chk({rail_discharge, rail_low_power, dual_gps_from_buck}, 9'h1E1);
    $display("test 2 done");
    {rstn, shutdown, gps_sel_1v3, radio_sel_2v5} = 4'h1;
    repeat (2) @(posedge core_clk);
    #1 rstn = 1;
    rall(32'h24243C07);
    $display("test 3 done");
    close_out;
  end
endmodule
